// ### src/pdc_map.vh
// register offsets, field positions and reset values of the pll divider and power control
`ifndef PDC_MAP_VH
`define PDC_MAP_VH

// ***********************************************************************
// register byte offsets (printed offset of the control word is 0x38)
// ***********************************************************************
`define PDC_OFF_CTRL      12'h038
`define PDC_OFF_MDIV      12'h03C
`define PDC_OFF_STATUS    12'h040

// ***********************************************************************
// field positions
// ***********************************************************************
`define PDC_PDN_BIT       0
`define PDC_SYNC_BIT      1
`define PDC_POST_LSB      2
`define PDC_POST_MSB      4
`define PDC_MDIV_MSB      4

// ***********************************************************************
// reset values
// ***********************************************************************
`define PDC_RST_POST      3'h7
`define PDC_RST_SYNC      1'b1
`define PDC_RST_PDN       1'b0
`define PDC_RST_MDIV      5'h00

// ***********************************************************************
// calibration timing
// ***********************************************************************
`define PDC_CAL_TIME_NS   1000
`define PDC_CLK_PERIOD_NS 4

`endif

// ### src/pdc_pll_ctrl.v
// apb register block for pll m divider, post divider, sync enable and power down
//
// Local design decision: the APB slave port.
`include "pdc_map.vh"

module pdc_pll_ctrl #(
    parameter CAL_CYCLES = (`PDC_CAL_TIME_NS + `PDC_CLK_PERIOD_NS - 1) / `PDC_CLK_PERIOD_NS
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        clk_en,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        sync_event_pin,
    output reg         m_div_bypass,
    output reg  [5:0]  m_div_ratio,
    output reg  [3:0]  post_div_ratio,
    output reg         pll_enable,
    output reg         cal_reset,
    output reg         cal_busy,
    output reg         cal_done,
    output reg         chan_resync
);

    // ***********************************************************************
    // declarations
    // ***********************************************************************
    localparam CAL_IDLE = 2'b00;
    localparam CAL_RUN  = 2'b01;
    localparam CAL_DONE = 2'b10;
    // last count of a run; the counter is 16 bits, so longer runs do not fit
    localparam [15:0] CAL_LAST = CAL_CYCLES - 1;

    reg  [4:0]  m_divider_ratio;
    reg  [2:0]  post_sel;
    reg         sync_en;
    reg         synth_power_down;
    reg  [1:0]  cal_state;
    reg  [15:0] cal_count;
    reg         sync_meta;
    reg         sync_sync;
    reg         sync_prev;
    reg  [1:0]  next_cal_state;

    // ***********************************************************************
    // bus decode
    // ***********************************************************************
    // clk_en low also stalls the bus, so a master must not give up on a wait
    wire        access  = psel && penable && clk_en;
    wire        wr      = access && pwrite;
    wire        wr_done = wr && pready;
    wire        hit_ctl = (paddr == `PDC_OFF_CTRL);
    wire        hit_mdv = (paddr == `PDC_OFF_MDIV);
    wire        hit_sts = (paddr == `PDC_OFF_STATUS);
    wire        mapped  = hit_ctl || hit_mdv || hit_sts;
    wire        sync_rise = sync_sync && !sync_prev;

    // ***********************************************************************
    // post divider decode
    // ***********************************************************************
    // decode used only for the output ratio; readback returns the raw post_sel code
    function [3:0] post_ratio;
        input [2:0] code;
        begin
            if (code < 3'h2) begin
                post_ratio = 4'h2;
            end else begin
                post_ratio = {1'b0, code} + 4'h1;
            end
        end
    endfunction

    // ***********************************************************************
    // bus handshake: one wait state on every access while clk_en stays high
    // ***********************************************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (clk_en) begin
            pready  <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !mapped;
        end
    end

    // ***********************************************************************
    // control registers
    // ***********************************************************************
    // writes land at the edge that completes the transfer, so an access
    // abandoned before pready never changes a setting
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            post_sel         <= `PDC_RST_POST;
            sync_en          <= `PDC_RST_SYNC;
            synth_power_down <= `PDC_RST_PDN;
            m_divider_ratio  <= `PDC_RST_MDIV;
        end else if (clk_en) begin
            if (wr_done && hit_ctl) begin
                // only defined fields are stored
                post_sel         <= pwdata[`PDC_POST_MSB:`PDC_POST_LSB];
                sync_en          <= pwdata[`PDC_SYNC_BIT];
                synth_power_down <= pwdata[`PDC_PDN_BIT];
            end
            if (wr_done && hit_mdv) begin
                m_divider_ratio <= pwdata[`PDC_MDIV_MSB:0];
            end
        end
    end

    // ***********************************************************************
    // read data
    // ***********************************************************************
    // captured at the same edge that raises pready so it stands when the master samples
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (clk_en) begin
            if (access && !pwrite && !pready) begin
                if (hit_ctl) begin
                    prdata <= {27'h000_0000, post_sel, sync_en, synth_power_down};
                end else if (hit_mdv) begin
                    prdata <= {27'h000_0000, m_divider_ratio};
                end else if (hit_sts) begin
                    prdata <= {28'h000_0000, cal_busy, cal_done, cal_reset, pll_enable};
                end else begin
                    prdata <= 32'h0000_0000;
                end
            end
        end
    end

    // ***********************************************************************
    // sync event pin and channel resync
    // ***********************************************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_meta   <= 1'b0;
            sync_sync   <= 1'b0;
            sync_prev   <= 1'b0;
            chan_resync <= 1'b0;
        end else if (clk_en) begin
            sync_meta   <= sync_event_pin;
            sync_sync   <= sync_meta;
            sync_prev   <= sync_sync;
            chan_resync <= sync_rise && sync_en;
        end
    end

    // ***********************************************************************
    // calibration sequencer
    // ***********************************************************************
    always @* begin
        next_cal_state = cal_state;
        case (cal_state)
            CAL_IDLE: next_cal_state = CAL_RUN;
            CAL_RUN: begin
                if (cal_count == CAL_LAST) begin
                    next_cal_state = CAL_DONE;
                end
            end
            CAL_DONE: next_cal_state = CAL_DONE;
            default:  next_cal_state = CAL_IDLE;
        endcase
        // power down forces the sequencer back to its start
        if (synth_power_down) begin
            next_cal_state = CAL_IDLE;
        end
    end

    // hardware reset leaves power down at 0, so calibration starts unprompted
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cal_state      <= CAL_IDLE;
            cal_count      <= 16'h0000;
            pll_enable     <= 1'b0;
            cal_reset      <= 1'b1;
            cal_busy       <= 1'b0;
            cal_done       <= 1'b0;
            m_div_bypass   <= 1'b1;
            m_div_ratio    <= 6'h01;
            post_div_ratio <= 4'h8;
        end else if (clk_en) begin
            cal_state      <= next_cal_state;
            cal_count      <= (next_cal_state == CAL_RUN && cal_state == CAL_RUN) ?
                              cal_count + 16'h0001 : 16'h0000;
            pll_enable     <= !synth_power_down;
            cal_reset      <= (next_cal_state == CAL_IDLE);
            cal_busy       <= (next_cal_state == CAL_RUN);
            cal_done       <= (next_cal_state == CAL_DONE);
            m_div_bypass   <= (m_divider_ratio == 5'h00);
            m_div_ratio    <= (m_divider_ratio == 5'h00) ? 6'h01 :
                              {1'b0, m_divider_ratio} + 6'h01;
            post_div_ratio <= post_ratio(post_sel);
        end
    end

endmodule

// ### dv/pdc_pll_ctrl_monitor.sv
// assertion checker for the pll divider and power control block
module pdc_pll_ctrl_monitor #(
    parameter int CAL_CYCLES = 4
) (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       clk_en,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pready,
    input wire logic       pslverr,
    input wire logic       m_div_bypass,
    input wire logic [5:0] m_div_ratio,
    input wire logic [3:0] post_div_ratio,
    input wire logic       pll_enable,
    input wire logic       cal_reset,
    input wire logic       cal_busy,
    input wire logic       cal_done,
    input wire logic       chan_resync
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup; psel && !penable && clk_en; endsequence
    // bounds are loose so a shortened calibration count still fits
    sequence s_cal_run; ##[0:3] cal_busy ##[1:300] cal_done; endsequence
    a_apb_wait: assert property (s_setup ##1 penable |-> !pready ##1 pready)
        else $error("apb access without exactly one wait state");
    a_ready_pulse: assert property (pready |=> !pready) else $error("pready longer than one cycle");
    a_err_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
    a_bypass_one: assert property (m_div_bypass |-> m_div_ratio == 6'h01)
        else $error("bypass with ratio not one");
    a_mdiv_range: assert property (!m_div_bypass |-> m_div_ratio inside {[2:32]})
        else $error("m ratio out of range");
    a_post_range: assert property (post_div_ratio inside {[2:8]})
        else $error("post ratio out of range");
    a_post_reset: assert property ($rose(presetn) |-> post_div_ratio == 4'h8)
        else $error("post ratio not eight after reset");
    a_pdn_hold: assert property (!pll_enable |-> cal_reset && !cal_busy && !cal_done)
        else $error("calibration not held while pll off");
    a_cal_restart: assert property ($rose(pll_enable) |-> s_cal_run)
        else $error("calibration did not run after enable");
    a_resync_pulse: assert property (chan_resync |=> !chan_resync)
        else $error("resync longer than one cycle");
endmodule
bind pdc_pll_ctrl pdc_pll_ctrl_monitor #(.CAL_CYCLES(CAL_CYCLES)) u_mon (.*);

// ### dv/tb_top.sv
// self-checking bench for the pll divider and power control block
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ***************************************
    // signals and divider table
    // ***************************************
    logic        pclk, presetn, clk_en, psel, penable, pwrite, sync_event_pin, pready, pslverr;
    logic        m_div_bypass, pll_enable, cal_reset, cal_busy, cal_done, chan_resync, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [5:0]  m_div_ratio;
    logic [3:0]  post_div_ratio;
    int          fail_count = 0, n_checks = 0;
    typedef struct packed {logic [4:0] m; logic [2:0] p; logic [5:0] em; logic [3:0] ep;} pdc_row_t;
    pdc_row_t rows[8] = '{'{5'h00, 3'h0, 6'h01, 4'h2}, '{5'h01, 3'h1, 6'h02, 4'h2},
        '{5'h02, 3'h2, 6'h03, 4'h3}, '{5'h0F, 3'h3, 6'h10, 4'h4}, '{5'h10, 3'h4, 6'h11, 4'h5},
        '{5'h1D, 3'h5, 6'h1E, 4'h6}, '{5'h1E, 3'h6, 6'h1F, 4'h7}, '{5'h1F, 3'h7, 6'h20, 4'h8}};
    pdc_pll_ctrl #(.CAL_CYCLES(4)) DUT (.*);
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // request held until pready is sampled high; idle cycle after release
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 40);
        rd = prdata; er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        if (n >= 40) fail_count++;
        @(posedge pclk);
    endtask
    task sync(input int exp);
        int c;
        c = 0;
        sync_event_pin <= 1'b1;
        repeat (10) begin @(posedge pclk); c += (chan_resync === 1'b1); end
        sync_event_pin <= 1'b0;
        repeat (4) @(posedge pclk);
        chk("resync count", c, exp);
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #10us;
        fail_count++;
        report_and_stop();
    end
    initial begin
        {presetn, psel, penable, pwrite, sync_event_pin, paddr, pwdata} = '0;
        clk_en = 1'b1;
        repeat (5) @(posedge pclk);
        chk("post in reset", post_div_ratio, 4'h8);
        presetn <= 1'b1;
        repeat (12) @(posedge pclk);
        chk("auto cal", {pll_enable, cal_done}, 2'b11);
        apb(0, 12'h038, 0); chk("ctrl reset", rd, 32'h0000_001E);
        apb(0, 12'h03C, 0); chk("mdiv reset", rd, 0);
        $display("reset test done");
        foreach (rows[i]) begin
            apb(1, 12'h03C, {27'h0, rows[i].m});
            apb(1, 12'h038, {27'h0, rows[i].p, 2'b10});
            repeat (2) @(posedge pclk);
            chk("m ratio", m_div_ratio, rows[i].em);
            chk("m bypass", m_div_bypass, rows[i].m == 0);
            chk("post ratio", post_div_ratio, rows[i].ep);
        end
        apb(1, 12'h03C, 32'hFFFF_FFFF); apb(0, 12'h03C, 0); chk("mdiv rsv", rd, 32'h0000_001F);
        apb(1, 12'h038, 32'hFFFF_FFE2); apb(0, 12'h038, 0); chk("ctrl rsv", rd, 32'h0000_0002);
        apb(0, 12'h044, 0); chk("unmapped err", er, 1); chk("unmapped data", rd, 0);
        $display("register test done");
        apb(1, 12'h038, 32'h0000_001F); repeat (2) @(posedge pclk);
        chk("power down", {pll_enable, cal_reset, cal_busy, cal_done}, 4'b0100);
        apb(0, 12'h040, 0); chk("status off", rd, 32'h0000_0002);
        apb(1, 12'h038, 32'h0000_001E); repeat (12) @(posedge pclk);
        apb(0, 12'h040, 0); chk("status recal", rd, 32'h0000_0005);
        sync(1);
        apb(1, 12'h038, 32'h0000_0000); sync(0);
        presetn <= 1'b0; @(posedge pclk);
        chk("mid reset post", post_div_ratio, 4'h8);
        presetn <= 1'b1; repeat (12) @(posedge pclk);
        $display("power and sync test done");
        report_and_stop();
    end
endmodule
